/* rtl/bscan_data_regs.sv */
// Test data registers and pin control of the boundary scan port
//
// Functional notes
// RULE_01: Bypass, boundary and identity registers in parallel, one selected.
// RULE_02: Boundary chain is selected for EXTEST and SAMPLE/PRELOAD.
// RULE_03: EXTEST made current drives held update latches onto pins at once.
// RULE_04: Tester preloads safe values by SAMPLE/PRELOAD before EXTEST.
// RULE_05: Every cell has an update latch taken on the falling test clock.
// RULE_06: Input-only pin cells only observe and never drive pin or core.
// RULE_07: Output enable cells have shift stage and latch steering the driver.
// RULE_08: Each two-way pin has one enable cell and one capture cell.
// RULE_09: Normal mode with enable high captures the core data toward the pad.
// RULE_10: Enable low or EXTEST captures the data arriving from the pad.
// RULE_11: Receive and system pins observe, transmit controls, two-way both.
// RULE_12: Mode and data sampled on rising test clock, output on falling.
// RULE_13: Serial output driven only in the two shift states.
// RULE_14: Bypass bit loads zero in Capture-DR.
// RULE_15: Cells capture, shift once per rising clock, then update.
`timescale 1ns/1ps
module bscan_data_regs #(
    parameter logic [31:0] ID_CODE = 32'h0A5C_3001 // Arbitrary value
) (
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_srst,
    input  wire logic                          i_tck,
    input  wire logic                          i_tms,
    input  wire logic                          i_tdi,
    input  wire logic                          i_trst_n,
    output logic                               o_tdo,
    output logic                               o_tdo_oe,
    input  wire logic [bscan_pkg::N_RX-1:0]    i_rx_lane,
    input  wire logic [bscan_pkg::N_SYS-1:0]   i_sys_in,
    input  wire logic [bscan_pkg::N_TX-1:0]    i_core_tx,
    output logic      [bscan_pkg::N_TX-1:0]    o_tx_lane,
    input  wire logic [bscan_pkg::N_BIDIR-1:0] i_core_bidir_out,
    input  wire logic [bscan_pkg::N_BIDIR-1:0] i_core_bidir_oe,
    input  wire logic [bscan_pkg::N_BIDIR-1:0] i_bidir_pad_in,
    output logic      [bscan_pkg::N_BIDIR-1:0] o_bidir_out,
    output logic      [bscan_pkg::N_BIDIR-1:0] o_bidir_oe
);
    bsc_chain_if bs ();

    logic [bscan_pkg::SYNC_W-1:0]  sync1_reg;
    logic [bscan_pkg::SYNC_W-1:0]  sync2_reg;
    logic                          tck_prev_reg;
    logic                          tck_s;
    logic                          tms_s;
    logic                          tdi_s;
    logic                          trst_n_s;
    logic                          tck_rise;
    logic                          tck_fall;
    logic [bscan_pkg::N_RX-1:0]    rx_s;
    logic [bscan_pkg::N_SYS-1:0]   sys_s;
    logic [bscan_pkg::N_BIDIR-1:0] pad_s;
    bscan_pkg::tap_state_t         tap_state_reg;
    bscan_pkg::tap_state_t         tap_state_next;
    logic [bscan_pkg::IR_W-1:0]    ir_shift_reg;
    logic [bscan_pkg::IR_W-1:0]    ir_reg;
    logic                          bypass_reg;
    logic [bscan_pkg::ID_W-1:0]    id_reg;
    logic                          sel_bsr;
    logic                          sel_id;
    logic                          extest_on;
    logic                          clamp_on;
    logic                          highz_on;
    logic                          test_drive;
    logic                          in_shift;
    wire  [bscan_pkg::N_BIDIR-1:0]   upd_oe_v;
    wire  [bscan_pkg::N_BIDIR-1:0]   upd_bd_v;
    wire  [2*bscan_pkg::N_BIDIR-1:0] bd_cap_v;

    // ------------------------------------------------------------
    // Pin synchronisers and test clock edge detection
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_trst_n, i_tck, i_tms, i_tdi,
                          i_bidir_pad_in, i_sys_in, i_rx_lane};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tck_prev_reg <= 1'b0;
        end else begin
            tck_prev_reg <= tck_s;
        end
    end

    assign {trst_n_s, tck_s, tms_s, tdi_s, pad_s, sys_s, rx_s} = sync2_reg;
    assign tck_rise = tck_s && !tck_prev_reg;
    assign tck_fall = !tck_s && tck_prev_reg;

    // ------------------------------------------------------------
    // Controller state, advanced on the rising test clock
    // ------------------------------------------------------------
    always_comb begin
        tap_state_next = tap_state_reg;
        case (tap_state_reg)
            bscan_pkg::TAP_RESET:  tap_state_next = tms_s ?
                bscan_pkg::TAP_RESET : bscan_pkg::TAP_IDLE;
            bscan_pkg::TAP_IDLE:   tap_state_next = tms_s ?
                bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
            bscan_pkg::TAP_SEL_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_SEL_IR : bscan_pkg::TAP_CAP_DR;
            bscan_pkg::TAP_CAP_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
            bscan_pkg::TAP_SH_DR:  tap_state_next = tms_s ?
                bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
            bscan_pkg::TAP_EX1_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_PAU_DR;
            bscan_pkg::TAP_PAU_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_EX2_DR : bscan_pkg::TAP_PAU_DR;
            bscan_pkg::TAP_EX2_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_SH_DR;
            bscan_pkg::TAP_UPD_DR: tap_state_next = tms_s ?
                bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
            bscan_pkg::TAP_SEL_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_RESET : bscan_pkg::TAP_CAP_IR;
            bscan_pkg::TAP_CAP_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
            bscan_pkg::TAP_SH_IR:  tap_state_next = tms_s ?
                bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
            bscan_pkg::TAP_EX1_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_PAU_IR;
            bscan_pkg::TAP_PAU_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_EX2_IR : bscan_pkg::TAP_PAU_IR;
            bscan_pkg::TAP_EX2_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_SH_IR;
            bscan_pkg::TAP_UPD_IR: tap_state_next = tms_s ?
                bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
            default:               tap_state_next = bscan_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !trst_n_s) begin
            tap_state_reg <= bscan_pkg::TAP_RESET;
        end else if (tck_rise) begin
            tap_state_reg <= tap_state_next; // RULE_12
        end
    end

    // ------------------------------------------------------------
    // Instruction register, made current on the falling edge
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !trst_n_s) begin
            ir_shift_reg <= bscan_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (tap_state_reg == bscan_pkg::TAP_CAP_IR) begin
                ir_shift_reg <= bscan_pkg::IR_CAPTURE;
            end else if (tap_state_reg == bscan_pkg::TAP_SH_IR) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[bscan_pkg::IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !trst_n_s) begin
            ir_reg <= bscan_pkg::OP_IDCODE;
        end else if (tap_state_reg == bscan_pkg::TAP_RESET) begin
            ir_reg <= bscan_pkg::OP_IDCODE;
        end else if (tck_fall && tap_state_reg == bscan_pkg::TAP_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // Unknown and reserved opcodes fall back to the bypass path
    assign extest_on  = (ir_reg == bscan_pkg::OP_EXTEST);
    assign sel_bsr    = extest_on ||
                        (ir_reg == bscan_pkg::OP_SAMPLE); // RULE_02
    assign sel_id     = (ir_reg == bscan_pkg::OP_IDCODE); // RULE_01
    assign clamp_on   = (ir_reg == bscan_pkg::OP_CLAMP);
    assign highz_on   = (ir_reg == bscan_pkg::OP_HIGHZ);
    assign test_drive = extest_on || clamp_on;
    assign in_shift   = (tap_state_reg == bscan_pkg::TAP_SH_DR) ||
                        (tap_state_reg == bscan_pkg::TAP_SH_IR);

    // ------------------------------------------------------------
    // Bypass and identity registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            bypass_reg <= bscan_pkg::BYPASS_CAPTURE;
        end else if (tck_rise && !sel_bsr && !sel_id) begin
            if (tap_state_reg == bscan_pkg::TAP_CAP_DR) begin
                bypass_reg <= bscan_pkg::BYPASS_CAPTURE; // RULE_14
            end else if (tap_state_reg == bscan_pkg::TAP_SH_DR) begin
                bypass_reg <= tdi_s;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            id_reg <= '0;
        end else if (tck_rise && sel_id) begin
            if (tap_state_reg == bscan_pkg::TAP_CAP_DR) begin
                id_reg <= ID_CODE;
            end else if (tap_state_reg == bscan_pkg::TAP_SH_DR) begin
                id_reg <= {tdi_s, id_reg[bscan_pkg::ID_W-1:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary cells; clock and resistor reference pins have none
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < bscan_pkg::N_BIDIR; gi++) begin : g_bidir
            localparam int OE_IX = bscan_pkg::BIDIR_BASE + 2 * gi
                                   + bscan_pkg::BIDIR_OE_OFS;
            localparam int DT_IX = bscan_pkg::BIDIR_BASE + 2 * gi
                                   + bscan_pkg::BIDIR_DT_OFS;
            assign bd_cap_v[2*gi+bscan_pkg::BIDIR_OE_OFS] =
                i_core_bidir_oe[gi]; // RULE_07
            assign bd_cap_v[2*gi+bscan_pkg::BIDIR_DT_OFS] =
                (!extest_on && i_core_bidir_oe[gi]) ?
                i_core_bidir_out[gi] : pad_s[gi]; // RULE_08 RULE_09 RULE_10
            assign upd_oe_v[gi] = bs.upd_data[OE_IX];
            assign upd_bd_v[gi] = bs.upd_data[DT_IX];
        end
    endgenerate

    // Receive and system cells only observe: RULE_06 RULE_11
    assign bs.cap_data = {bd_cap_v, i_core_tx, sys_s, rx_s};
    assign bs.tdi      = tdi_s;
    assign bs.capture  = tck_rise && sel_bsr &&
                         (tap_state_reg == bscan_pkg::TAP_CAP_DR); // RULE_15
    assign bs.shift    = tck_rise && sel_bsr &&
                         (tap_state_reg == bscan_pkg::TAP_SH_DR); // RULE_15
    assign bs.update   = tck_fall && sel_bsr &&
                         (tap_state_reg == bscan_pkg::TAP_UPD_DR); // RULE_05

    bscan_cells u_cells (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .bs        (bs)
    );

    // ------------------------------------------------------------
    // Serial output, changed on the falling test clock
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !trst_n_s) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo_oe <= in_shift; // RULE_13
            if (tap_state_reg == bscan_pkg::TAP_SH_IR) begin
                o_tdo <= ir_shift_reg[0];
            end else if (sel_bsr) begin
                o_tdo <= bs.so; // RULE_01 RULE_12
            end else if (sel_id) begin
                o_tdo <= id_reg[0];
            end else begin
                o_tdo <= bypass_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers: core in normal mode, update latches under test
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_tx_lane   <= '0;
            o_bidir_out <= '0;
            o_bidir_oe  <= '0;
        end else begin
            o_tx_lane   <= test_drive ?
                bs.upd_data[bscan_pkg::TX_BASE +: bscan_pkg::N_TX] :
                i_core_tx; // RULE_03
            o_bidir_out <= test_drive ? upd_bd_v : i_core_bidir_out;
            o_bidir_oe  <= highz_on ? '0 :
                (test_drive ? upd_oe_v : i_core_bidir_oe); // RULE_07
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_shift_dr_fall;
        tck_fall && tap_state_reg == bscan_pkg::TAP_SH_DR;
    endsequence

    sequence s_capture_dr_rise;
        tck_rise && tap_state_reg == bscan_pkg::TAP_CAP_DR;
    endsequence

    property p_bsr_to_tdo;
        @(posedge i_ref_clk) disable iff (i_srst || !trst_n_s)
        s_shift_dr_fall ##0 sel_bsr |=> o_tdo == $past(bs.so) && o_tdo_oe;
    endproperty
    a_bsr_to_tdo: assert property (p_bsr_to_tdo) // RULE_02
        else $error("Boundary chain not on the serial output");

    property p_id_to_tdo;
        @(posedge i_ref_clk) disable iff (i_srst || !trst_n_s)
        s_shift_dr_fall ##0 sel_id |=> o_tdo == $past(id_reg[0]);
    endproperty
    a_id_to_tdo: assert property (p_id_to_tdo) // RULE_01
        else $error("Identity register not on the serial output");

    property p_bypass_zero;
        @(posedge i_ref_clk) disable iff (i_srst || !trst_n_s)
        s_capture_dr_rise ##0 (!sel_bsr && !sel_id) |=> bypass_reg == 1'b0;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) // RULE_14
        else $error("Bypass bit did not capture zero");

    property p_tdo_hiz;
        @(posedge i_ref_clk) disable iff (i_srst || !trst_n_s)
        tck_fall && !in_shift |=> !o_tdo_oe [*2];
    endproperty
    a_tdo_hiz: assert property (p_tdo_hiz) // RULE_13
        else $error("Serial output enabled outside a shift state");

    property p_state_on_rise;
        @(posedge i_ref_clk) disable iff (i_srst || !trst_n_s)
        !$stable(tap_state_reg) |-> $past(tck_rise);
    endproperty
    a_state_on_rise: assert property (p_state_on_rise) // RULE_12
        else $error("Controller moved without a rising test clock");

    property p_extest_drive;
        @(posedge i_ref_clk) disable iff (i_srst)
        extest_on |=> o_tx_lane ==
            $past(bs.upd_data[bscan_pkg::TX_BASE +: bscan_pkg::N_TX])
            && o_bidir_out == $past(upd_bd_v);
    endproperty
    a_extest_drive: assert property (p_extest_drive) // RULE_03
        else $error("EXTEST pins differ from update latches");

    property p_extest_oe;
        @(posedge i_ref_clk) disable iff (i_srst)
        extest_on |=> o_bidir_oe == $past(upd_oe_v);
    endproperty
    a_extest_oe: assert property (p_extest_oe) // RULE_07
        else $error("EXTEST enables differ from enable latches");

    property p_cap_core;
        @(posedge i_ref_clk) disable iff (i_srst)
        bs.capture && !extest_on && i_core_bidir_oe[0] |=>
            u_cells.shift_reg[bscan_pkg::BIDIR_BASE + bscan_pkg::BIDIR_DT_OFS]
            == $past(i_core_bidir_out[0]);
    endproperty
    a_cap_core: assert property (p_cap_core) // RULE_09
        else $error("Two-way cell did not capture core data");

    property p_cap_pad;
        @(posedge i_ref_clk) disable iff (i_srst)
        bs.capture && (extest_on || !i_core_bidir_oe[0]) |=>
            u_cells.shift_reg[bscan_pkg::BIDIR_BASE + bscan_pkg::BIDIR_DT_OFS]
            == $past(pad_s[0]);
    endproperty
    a_cap_pad: assert property (p_cap_pad) // RULE_10
        else $error("Two-way cell did not capture pad data");

    property p_update_on_fall;
        @(posedge i_ref_clk) disable iff (i_srst)
        !$stable(u_cells.upd_reg) |->
            $past(tck_fall) && $past(tap_state_reg) == bscan_pkg::TAP_UPD_DR;
    endproperty
    a_update_on_fall: assert property (p_update_on_fall) // RULE_05
        else $error("Update latch strobed off the falling edge");
endmodule

/* rtl/bscan_pkg.sv */
// Constants, opcodes and types shared by the boundary scan data registers
package bscan_pkg;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int         IR_W       = 6;
    localparam logic [5:0] OP_EXTEST  = 6'h00;
    localparam logic [5:0] OP_SAMPLE  = 6'h01;
    localparam logic [5:0] OP_IDCODE  = 6'h02;
    localparam logic [5:0] OP_HIGHZ   = 6'h03;
    localparam logic [5:0] OP_CLAMP   = 6'h3E;
    localparam logic [5:0] OP_BYPASS  = 6'h3F;
    localparam logic [5:0] IR_CAPTURE = 6'h2D;

    // ------------------------------------------------------------
    // Pin groups and chain layout, cell 0 sits next to the output
    // ------------------------------------------------------------
    localparam int N_RX         = 12;
    localparam int N_SYS        = 3;
    localparam int N_TX         = 6;
    localparam int N_BIDIR      = 11;
    localparam int RX_BASE      = 0;
    localparam int SYS_BASE     = RX_BASE + N_RX;
    localparam int TX_BASE      = SYS_BASE + N_SYS;
    localparam int BIDIR_BASE   = TX_BASE + N_TX;
    localparam int BIDIR_OE_OFS = 0;
    localparam int BIDIR_DT_OFS = 1;
    localparam int CHAIN_LEN    = BIDIR_BASE + 2 * N_BIDIR;
    localparam int SYNC_W       = N_RX + N_SYS + N_BIDIR + 4;

    // ------------------------------------------------------------
    // Data register constants
    // ------------------------------------------------------------
    localparam int   ID_W           = 32;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // Test access port controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } tap_state_t;

endpackage

/* rtl/bsc_chain_if.sv */
// Strobes and data between the scan controller and the boundary cells
`timescale 1ns/1ps
interface bsc_chain_if;
    logic                           capture;
    logic                           shift;
    logic                           update;
    logic                           tdi;
    logic                           so;
    logic [bscan_pkg::CHAIN_LEN-1:0] cap_data;
    logic [bscan_pkg::CHAIN_LEN-1:0] upd_data;

    modport chain (
        input  capture,
        input  shift,
        input  update,
        input  tdi,
        input  cap_data,
        output so,
        output upd_data
    );

    modport ctrl (
        output capture,
        output shift,
        output update,
        output tdi,
        output cap_data,
        input  so,
        input  upd_data
    );
endinterface

/* rtl/bscan_cells.sv */
// Boundary cell storage: shift stages and update latches
`timescale 1ns/1ps
module bscan_cells (
    input  wire logic  i_ref_clk,
    input  wire logic  i_srst,
    bsc_chain_if.chain bs
);
    logic [bscan_pkg::CHAIN_LEN-1:0] shift_reg;
    logic [bscan_pkg::CHAIN_LEN-1:0] upd_reg;

    // ------------------------------------------------------------
    // Shift stages
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            shift_reg <= '0;
        end else if (bs.capture) begin
            shift_reg <= bs.cap_data; // RULE_15
        end else if (bs.shift) begin
            shift_reg <= {bs.tdi,
                          shift_reg[bscan_pkg::CHAIN_LEN-1:1]}; // RULE_15
        end
    end

    // ------------------------------------------------------------
    // Update latches, strobed only on a falling test clock
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            upd_reg <= '0;
        end else if (bs.update) begin
            upd_reg <= shift_reg; // RULE_05
        end
    end

    assign bs.so       = shift_reg[0];
    assign bs.upd_data = upd_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cell_capture;
        @(posedge i_ref_clk) disable iff (i_srst)
        bs.capture |=> shift_reg == $past(bs.cap_data);
    endproperty
    a_cell_capture: assert property (p_cell_capture) // RULE_15
        else $error("Capture did not load the cells");

    property p_cell_shift;
        @(posedge i_ref_clk) disable iff (i_srst)
        bs.shift && !bs.capture |=>
            shift_reg == {$past(bs.tdi),
                $past(shift_reg[bscan_pkg::CHAIN_LEN-1:1])};
    endproperty
    a_cell_shift: assert property (p_cell_shift) // RULE_15
        else $error("Shift did not move one cell toward the output");

    property p_cell_update;
        @(posedge i_ref_clk) disable iff (i_srst)
        bs.update |=> upd_reg == $past(shift_reg) ##1 $stable(upd_reg);
    endproperty
    a_cell_update: assert property (p_cell_update) // RULE_05
        else $error("Update latches did not take the shift stages");
endmodule

/* verif/jtag_tester.sv */
// Boundary-scan tester model driving the test link
`timescale 1ns/1ps
module jtag_tester (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // Set inputs while low, read output just before the rise
    task automatic tick(input logic tms, input logic tdi,
                        output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #62.5 tdo = i_tdo;
        o_tck = 1'b1;
        #62.5 o_tck = 1'b0;
    endtask
    task automatic idle;
        logic t;
        repeat (5) tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask
    // From idle: one IR or DR scan of n bits, back to idle
    task automatic scan(input logic ir, input logic [63:0] din,
                        input int n, output logic [63:0] dout);
        logic t;
        dout = '0;
        tick(1'b1, 1'b1, t);
        if (ir) tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
        tick(1'b0, 1'b1, t);
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask
endmodule

/* verif/test_boundary_scan_data_registers.sv */
// Self-checking bench for the boundary scan data registers
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    errors++; $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module test_boundary_scan_data_registers;
    logic        i_ref_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        trst_n = 1'b1;
    logic        tck, tms, tdi, o_tdo, o_tdo_oe;
    logic [11:0] rx = '0;
    logic [2:0]  sys = '0;
    logic [5:0]  ctx = '0, tx;
    logic [10:0] cout = '0, coe = '0, pad = '0, bout, boe;
    logic [63:0] d, p;
    int          errors = 0, cmp_count = 0;
    initial forever #5 i_ref_clk = ~i_ref_clk;
    jtag_tester u_tst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(o_tdo));
    // Identity value is arbitrary
    bscan_data_regs #(.ID_CODE(32'h5AC3_96E1)) u_dut (.i_ref_clk,
        .i_srst, .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
        .o_tdo, .o_tdo_oe, .i_rx_lane(rx), .i_sys_in(sys),
        .i_core_tx(ctx), .o_tx_lane(tx), .i_core_bidir_out(cout),
        .i_core_bidir_oe(coe), .i_bidir_pad_in(pad),
        .o_bidir_out(bout), .o_bidir_oe(boe));
    function automatic logic [63:0] cap(input logic ext);
        logic [63:0] c;
        c = '0;
        c[20:0] = {ctx, sys, rx};
        for (int i = 0; i < 11; i++) begin
            c[21 + 2 * i] = coe[i];
            c[22 + 2 * i] = (!ext && coe[i]) ? cout[i] : pad[i];
        end
        return c;
    endfunction
    function automatic logic [10:0] pick(input logic [63:0] v, int o);
        for (int i = 0; i < 11; i++) pick[i] = v[21 + o + 2 * i];
    endfunction
    task automatic stir;
        @(posedge i_ref_clk);
        {rx, sys, ctx} <= 21'($urandom);
        {cout, coe, pad} <= 33'({$urandom, $urandom});
        repeat (10) @(posedge i_ref_clk);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #900us;
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hDBB0));
        repeat (4) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        u_tst.idle();
        u_tst.scan(1'b0, 64'h0, 32, d);
        `CHK("idcode", 64'h5AC396E1, d)
        repeat (10) @(posedge i_ref_clk);
        `CHK("tdo_oe", 1'b0, o_tdo_oe)
        u_tst.scan(1'b1, 64'h3F, 6, d);
        u_tst.scan(1'b0, 64'h3, 3, d);
        `CHK("bypass", 64'h6, d)
        repeat (3) begin
            stir();
            u_tst.scan(1'b1, 64'h1, 6, d);
            p = {$urandom, $urandom};
            u_tst.scan(1'b0, p, 43, d);
            `CHK("sample", cap(1'b0), d)
            `CHK("tx_core", ctx, tx)
            `CHK("bout_core", cout, bout)
            u_tst.scan(1'b1, 64'h0, 6, d);
            repeat (6) @(posedge i_ref_clk);
            `CHK("tx_ext", p[20:15], tx)
            `CHK("oe_ext", pick(p, 0), boe)
            `CHK("out_ext", pick(p, 1), bout)
            stir();
            `CHK("tx_hold", p[20:15], tx)
            p = {$urandom, $urandom};
            u_tst.scan(1'b0, p, 43, d);
            `CHK("ext_cap", cap(1'b1), d)
            repeat (6) @(posedge i_ref_clk);
            `CHK("upd_tx", p[20:15], tx)
            `CHK("upd_oe", pick(p, 0), boe)
        end
        u_tst.scan(1'b1, 64'h3E, 6, d);
        repeat (6) @(posedge i_ref_clk);
        `CHK("tx_clamp", p[20:15], tx)
        u_tst.scan(1'b0, 64'h3, 3, d);
        `CHK("clamp_byp", 64'h6, d)
        u_tst.scan(1'b1, 64'h3, 6, d);
        repeat (6) @(posedge i_ref_clk);
        `CHK("oe_highz", 11'h0, boe)
        @(posedge i_ref_clk);
        trst_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        trst_n <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        `CHK("oe_trst", coe, boe)
        u_tst.tick(1'b0, 1'b1, d[0]);
        u_tst.scan(1'b0, 64'h0, 32, d);
        `CHK("id_trst", 64'h5AC396E1, d)
        wrap_up();
    end
endmodule
